//--- rtl/rsc_params.svh
// constants for the reset source controller
// Function
// - any active source asserts master reset
// - each reset sets its cause flag
// - power-on clears flags, sets power-on flag
// - software sets/clears flags, never causes reset
// - trap flag bit 15, cleared by power/brownout
// - illegal operation flag bit 14, power/brownout clear
// - pin flag bit 7, cleared only by power-on
// - instruction flag bit 6, power/brownout clear
// - watchdog flag bit 4, power-save clears too
// - sleep bit 3, idle bit 2 set by power-save
// - brownout and power-on flags reset to one
// - soft watchdog enable, fuse forces enable
// - regulator sleep bit 8, bits 13-9 zero
// - switching on: power resets load config select
// - switching off: always config select
// - release after power-on and powerup delays
// - clock waits concurrent; code waits for clock
// - power-on holds delay plus startup plus internal
// - startup 20us regulator, 64ms without; wake
// - other resets delay internal time only
// - crystal: count 1024 oscillator periods
// - pll lock wait, then monitor start delay
// - monitor without clock switches to fast RC
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_CLK_PERIOD_NS 8
`define RSC_T_POR_NS 10000
`define RSC_T_STARTUP_REG_NS 20000
`define RSC_T_STARTUP_NOREG_NS 64000000
`define RSC_T_RST_NS 20000
`define RSC_T_LOCK_NS 20000
`define RSC_T_MON_NS 100000
`define RSC_CYC_UP(t) (((t) + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_POR_CYC `RSC_CYC_UP(`RSC_T_POR_NS)
`define RSC_SU_REG_CYC `RSC_CYC_UP(`RSC_T_STARTUP_REG_NS)
`define RSC_SU_NOREG_CYC `RSC_CYC_UP(`RSC_T_STARTUP_NOREG_NS)
`define RSC_RST_CYC `RSC_CYC_UP(`RSC_T_RST_NS)
`define RSC_LOCK_CYC `RSC_CYC_UP(`RSC_T_LOCK_NS)
`define RSC_MON_CYC `RSC_CYC_UP(`RSC_T_MON_NS)
`define RSC_CNT_W 23
`define RSC_OST_W 10
`define RSC_ADDR_W 8
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_STATUS 8'h04
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_DECERR 2'h3
`define RSC_B_POR 0
`define RSC_B_BOR 1
`define RSC_B_IDLE 2
`define RSC_B_SLEEP 3
`define RSC_B_WATCHDOG_TIMEOUT_FLAG 4
`define RSC_B_SWDT 5
`define RSC_B_INSTR 6
`define RSC_B_PIN 7
`define RSC_B_VREG 8
`define RSC_B_ILLOP 14
`define RSC_B_TRAP 15
`define RSC_CAUSE_RST 16'h0003
`define RSC_CAUSE_MASK 16'hC1FF
`define RSC_S_OSC 0
`define RSC_S_WDOG 3
`define RSC_S_CLKOK 4
`define RSC_S_MON 5
`define RSC_S_RUN 6
`define RSC_S_MRST 7
`define RSC_OSC_FRC 3'h0
`define RSC_OSC_FRCPLL 3'h1
`define RSC_OSC_PRI 3'h2
`define RSC_OSC_PRIPLL 3'h3
`define RSC_OSC_SEC 3'h4
`endif

//--- rtl/rsc_pkg.sv
// types for the reset source controller
package rsc_pkg;
   typedef enum logic [2:0]
   {
      RSC_ST_POR = 3'h0,
      RSC_ST_STARTUP = 3'h1,
      RSC_ST_RST = 3'h2,
      RSC_ST_RUN = 3'h3,
      RSC_ST_WAKE = 3'h4
   } rsc_state_e;
   typedef logic [15:0] rsc_cause_t;
endpackage

//--- rtl/rsc_delay_timer.sv
// load-and-count-down delay timer
`timescale 1ns/1ps
module rsc_delay_timer #(
   parameter int W = 23
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic done
);
   logic [W-1:0] cnt;

   // a load of n cycles raises done n cycles later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt <= '0;
      else if (load)
         cnt <= load_value - 1'b1;
      else if (cnt != '0)
         cnt <= cnt - 1'b1;
   end

   // done does not look at load, so a caller may derive load from done
   assign done = (cnt == '0);
endmodule

//--- rtl/rsc_osc_startup.sv
// oscillator start-up period counter
`timescale 1ns/1ps
module rsc_osc_startup #(
   parameter int W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic osc_tick,
   output logic done
);
   logic [W-1:0] cnt;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt <= '0;
         done <= 1'b0;
      end
      else if (restart)
      begin
         cnt <= '0;
         done <= 1'b0;
      end
      else if (osc_tick && !done)
      begin
         cnt <= cnt + 1'b1;
         if (cnt == {W{1'b1}})
            done <= 1'b1;
      end
   end
endmodule

//--- rtl/rsc_top.sv
// reset source controller: cause register, release sequencing, clock choice
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_top #(
   parameter int POR_CYC = `RSC_POR_CYC,
   parameter int SU_REG_CYC = `RSC_SU_REG_CYC,
   parameter int SU_NOREG_CYC = `RSC_SU_NOREG_CYC,
   parameter int RST_CYC = `RSC_RST_CYC,
   parameter int LOCK_CYC = `RSC_LOCK_CYC,
   parameter int MON_CYC = `RSC_MON_CYC,
   parameter int CNT_W = `RSC_CNT_W,
   parameter int OST_W = `RSC_OST_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`RSC_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`RSC_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic por_event,
   input wire logic brownout_reset,
   input wire logic external_pin_reset,
   input wire logic reset_instr,
   input wire logic watchdog_timeout,
   input wire logic trap_conflict,
   input wire logic illegal_operation,
   input wire logic sleep_entry,
   input wire logic idle_entry,
   input wire logic wake_request,
   input wire logic regulator_enable,
   input wire logic fuse_watchdog_enable,
   input wire logic clock_switch_enable,
   input wire logic clock_fail_monitor_enable,
   input wire logic [2:0] config_osc_select,
   input wire logic osc_tick,
   output logic master_reset_out,
   output logic clock_released,
   output logic code_run_enable,
   output logic monitor_active,
   output logic [2:0] current_osc_select,
   output logic watchdog_enabled,
   output logic regulator_sleep_active
);
   // ==========================================================
   // decode helpers
   function automatic logic osc_is_crystal(input logic [2:0] sel);
      return (sel == `RSC_OSC_PRI) || (sel == `RSC_OSC_PRIPLL) || (sel == `RSC_OSC_SEC);
   endfunction

   function automatic logic osc_is_pll(input logic [2:0] sel);
      return (sel == `RSC_OSC_FRCPLL) || (sel == `RSC_OSC_PRIPLL);
   endfunction

   function automatic logic [1:0] addr_resp(input logic [`RSC_ADDR_W-1:0] a);
      if (a == `RSC_OFF_CAUSE)
         return `RSC_RESP_OKAY;
      else if (a == `RSC_OFF_STATUS)
         return `RSC_RESP_OKAY;
      else
         return `RSC_RESP_DECERR;
   endfunction

   // ==========================================================
   // sources and sequencing state
   rsc_pkg::rsc_state_e state;
   rsc_pkg::rsc_state_e next_state;
   rsc_pkg::rsc_cause_t cause;
   rsc_pkg::rsc_cause_t next_cause;
   logic first;
   logic power_evt;
   logic por_like;
   logic any_src;
   logic soft_src;
   logic pwr_path;
   logic main_load;
   logic [CNT_W-1:0] main_value;
   logic main_done;
   logic main_exp;
   logic aux_load;
   logic [CNT_W-1:0] aux_value;
   logic aux_done;
   logic ost_done;
   logic clk_ok;
   logic pll_wait;
   logic mon_wait;
   logic need_ost;
   logic need_pll;
   logic start_lock;
   logic mon_start;
   logic clock_fail_monitor_switch;
   logic wr_cause;
   logic do_write;
   logic aw_held;
   logic w_held;
   logic [`RSC_ADDR_W-1:0] aw_addr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [15:0] rst_len;

   assign power_evt = por_event | brownout_reset;
   assign por_like = first | power_evt;
   assign any_src = power_evt | external_pin_reset | reset_instr | watchdog_timeout
                    | trap_conflict | illegal_operation;
   assign soft_src = any_src & ~power_evt;
   // expiry ignores reload cycles, keeping the timer load out of a loop
   assign main_exp = main_done & ~first & ~any_src;
   assign need_ost = osc_is_crystal(current_osc_select);
   assign need_pll = osc_is_pll(current_osc_select);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         first <= 1'b1;
      else
         first <= 1'b0;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         rsc_pkg::RSC_ST_POR:
            if (main_exp)
               next_state = rsc_pkg::RSC_ST_STARTUP;
         rsc_pkg::RSC_ST_STARTUP:
            if (main_exp)
               next_state = rsc_pkg::RSC_ST_RST;
         rsc_pkg::RSC_ST_RST:
            if (main_exp)
               next_state = rsc_pkg::RSC_ST_RUN;
         rsc_pkg::RSC_ST_RUN:
            if (wake_request && regulator_enable)
               next_state = rsc_pkg::RSC_ST_WAKE;
         rsc_pkg::RSC_ST_WAKE:
            if (main_exp)
               next_state = rsc_pkg::RSC_ST_RUN;
         default:
            next_state = rsc_pkg::RSC_ST_POR;
      endcase
      if (power_evt)
         next_state = rsc_pkg::RSC_ST_POR;
      else if (soft_src && state != rsc_pkg::RSC_ST_POR && state != rsc_pkg::RSC_ST_STARTUP)
         next_state = rsc_pkg::RSC_ST_RST;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= rsc_pkg::RSC_ST_POR;
         pwr_path <= 1'b1;
      end
      else
      begin
         state <= next_state;
         if (power_evt)
            pwr_path <= 1'b1;
         else if (soft_src && state != rsc_pkg::RSC_ST_RST)
            pwr_path <= 1'b0;
      end
   end

   // held sources keep reloading, so delays count from their release
   assign main_load = first | any_src | (next_state != state);
   always_comb
   begin
      case (next_state)
         rsc_pkg::RSC_ST_POR:
            main_value = CNT_W'(POR_CYC);
         rsc_pkg::RSC_ST_STARTUP:
            main_value = regulator_enable ? CNT_W'(SU_REG_CYC) : CNT_W'(SU_NOREG_CYC);
         rsc_pkg::RSC_ST_RST:
            main_value = CNT_W'(RST_CYC);
         rsc_pkg::RSC_ST_WAKE:
            main_value = CNT_W'(SU_REG_CYC);
         default:
            main_value = CNT_W'(1);
      endcase
   end

   rsc_delay_timer #(.W(CNT_W)) u_main_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(main_load),
      .load_value(main_value),
      .done(main_done)
   );

   assign master_reset_out = any_src | ((state != rsc_pkg::RSC_ST_RUN)
                             && (state != rsc_pkg::RSC_ST_WAKE));
   assign code_run_enable = (state == rsc_pkg::RSC_ST_RUN) && clk_ok && !any_src;

   // ==========================================================
   // clock release path, runs alongside the reset delays
   assign clock_fail_monitor_switch = (state == rsc_pkg::RSC_ST_RST) && (next_state == rsc_pkg::RSC_ST_RUN)
                        && clock_fail_monitor_enable && !clk_ok;
   assign start_lock = !por_like && !clock_fail_monitor_switch && !clk_ok && !pll_wait
                       && (!need_ost || ost_done) && need_pll;
   assign mon_start = (state == rsc_pkg::RSC_ST_RUN) && pwr_path && clk_ok && !mon_wait
                      && !monitor_active && clock_fail_monitor_enable && (need_ost || need_pll);
   assign aux_load = start_lock | mon_start;
   assign aux_value = mon_start ? CNT_W'(MON_CYC) : CNT_W'(LOCK_CYC);

   rsc_osc_startup #(.W(OST_W)) u_ost (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(por_like),
      .osc_tick(osc_tick),
      .done(ost_done)
   );

   rsc_delay_timer #(.W(CNT_W)) u_aux_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(aux_load),
      .load_value(aux_value),
      .done(aux_done)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_ok <= 1'b0;
         pll_wait <= 1'b0;
      end
      else if (por_like)
      begin
         clk_ok <= 1'b0;
         pll_wait <= 1'b0;
      end
      else if (clock_fail_monitor_switch)
      begin
         clk_ok <= 1'b1;
         pll_wait <= 1'b0;
      end
      else if (pll_wait)
      begin
         if (aux_done)
         begin
            clk_ok <= 1'b1;
            pll_wait <= 1'b0;
         end
      end
      else if (start_lock)
         pll_wait <= 1'b1;
      else if (!clk_ok && (!need_ost || ost_done))
         clk_ok <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mon_wait <= 1'b0;
         monitor_active <= 1'b0;
      end
      else if (por_like || any_src)
      begin
         mon_wait <= 1'b0;
         monitor_active <= 1'b0;
      end
      else if (state == rsc_pkg::RSC_ST_RUN && clock_fail_monitor_enable && !monitor_active)
      begin
         if (!(pwr_path && (need_ost || need_pll)))
            monitor_active <= 1'b1;
         else if (mon_start)
            mon_wait <= 1'b1;
         else if (mon_wait && aux_done)
         begin
            monitor_active <= 1'b1;
            mon_wait <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         current_osc_select <= `RSC_OSC_FRC;
      else if (por_like || (any_src && !clock_switch_enable))
         current_osc_select <= config_osc_select;
      else if (clock_fail_monitor_switch)
         current_osc_select <= `RSC_OSC_FRC;
   end

   assign clock_released = clk_ok;

   // ==========================================================
   // cause register
   always_comb
   begin
      next_cause = cause;
      if (wr_cause)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (wstrb_q[b])
               next_cause[b*8 +: 8] = wdata_q[b*8 +: 8];
         end
      end
      if (first || por_event)
         next_cause = '0;
      else if (brownout_reset)
      begin
         next_cause[`RSC_B_TRAP] = 1'b0;
         next_cause[`RSC_B_ILLOP] = 1'b0;
         next_cause[`RSC_B_INSTR] = 1'b0;
         next_cause[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
         next_cause[`RSC_B_SLEEP] = 1'b0;
         next_cause[`RSC_B_IDLE] = 1'b0;
      end
      if (sleep_entry || idle_entry)
         next_cause[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      // hardware sets come last so they win over any clear
      if (trap_conflict)
         next_cause[`RSC_B_TRAP] = 1'b1;
      if (illegal_operation)
         next_cause[`RSC_B_ILLOP] = 1'b1;
      if (external_pin_reset)
         next_cause[`RSC_B_PIN] = 1'b1;
      if (reset_instr)
         next_cause[`RSC_B_INSTR] = 1'b1;
      if (watchdog_timeout)
         next_cause[`RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      if (sleep_entry)
         next_cause[`RSC_B_SLEEP] = 1'b1;
      if (idle_entry)
         next_cause[`RSC_B_IDLE] = 1'b1;
      if (por_like)
         next_cause[`RSC_B_BOR] = 1'b1;
      if (first || por_event)
         next_cause[`RSC_B_POR] = 1'b1;
      next_cause = next_cause & `RSC_CAUSE_MASK;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cause <= `RSC_CAUSE_RST;
      else
         cause <= next_cause;
   end

   assign watchdog_enabled = fuse_watchdog_enable | cause[`RSC_B_SWDT];
   assign regulator_sleep_active = cause[`RSC_B_VREG];

   // ==========================================================
   // axi4-lite slave
   assign awready = !aw_held;
   assign wready = !w_held;
   assign arready = !rvalid;
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_cause = do_write && (aw_addr_q == `RSC_OFF_CAUSE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (wvalid && wready)
         begin
            w_held <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= `RSC_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp <= addr_resp(aw_addr_q);
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rresp <= `RSC_RESP_OKAY;
         rdata <= '0;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp <= addr_resp(araddr);
         rdata <= '0;
         if (araddr == `RSC_OFF_CAUSE)
            rdata[15:0] <= cause;
         else if (araddr == `RSC_OFF_STATUS)
         begin
            rdata[`RSC_S_OSC +: 3] <= current_osc_select;
            rdata[`RSC_S_WDOG] <= watchdog_enabled;
            rdata[`RSC_S_CLKOK] <= clk_ok;
            rdata[`RSC_S_MON] <= monitor_active;
            rdata[`RSC_S_RUN] <= code_run_enable;
            rdata[`RSC_S_MRST] <= master_reset_out;
         end
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // ==========================================================
   // checks
   always_ff @(posedge aclk)
   begin
      if (!aresetn || main_load)
         rst_len <= 16'h0000;
      else if (rst_len != 16'hFFFF)
         rst_len <= rst_len + 16'h0001;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_power;
      por_event || brownout_reset;
   endsequence
   sequence s_enter_run;
      state == rsc_pkg::RSC_ST_RST && next_state == rsc_pkg::RSC_ST_RUN;
   endsequence

   property p_src_reset;
      any_src |-> master_reset_out;
   endproperty
   a_src_reset: assert property (p_src_reset) else $error("source without master reset");
   property p_pin_flag;
      external_pin_reset |=> cause[`RSC_B_PIN];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");
   property p_por_clear;
      por_event && !soft_src && !sleep_entry && !idle_entry
         |=> (cause[15:2] == 14'h0000) && (cause[1:0] == 2'h3);
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-on flags wrong");
   property p_bor_keeps_pin;
      brownout_reset && !por_event && !wr_cause && !external_pin_reset
         |=> cause[`RSC_B_PIN] == $past(cause[`RSC_B_PIN]) && cause[`RSC_B_TRAP] == 1'b0;
   endproperty
   a_bor_keeps_pin: assert property (p_bor_keeps_pin) else $error("brownout flag clear");
   property p_hw_wins;
      watchdog_timeout && wr_cause && !power_evt |=> cause[`RSC_B_WATCHDOG_TIMEOUT_FLAG];
   endproperty
   a_hw_wins: assert property (p_hw_wins) else $error("clear beat watchdog set");
   property p_wdog;
      fuse_watchdog_enable |-> watchdog_enabled;
   endproperty
   a_wdog: assert property (p_wdog) else $error("fuse did not force watchdog");
   property p_unimpl;
      cause[13:9] == 5'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");
   property p_osc_por;
      s_power |=> current_osc_select == $past(config_osc_select);
   endproperty
   a_osc_por: assert property (p_osc_por) else $error("power reset osc select");
   property p_osc_keep;
      clock_switch_enable && soft_src && !clock_fail_monitor_switch |=> $stable(current_osc_select);
   endproperty
   a_osc_keep: assert property (p_osc_keep) else $error("osc select changed");
   property p_rst_time;
      s_enter_run |-> rst_len == 16'(RST_CYC - 1);
   endproperty
   a_rst_time: assert property (p_rst_time) else $error("internal reset time wrong");
   property p_run_needs_clk;
      code_run_enable |-> clk_ok && !master_reset_out;
   endproperty
   a_run_needs_clk: assert property (p_run_needs_clk) else $error("run without clock");
   property p_clock_fail_monitor;
      s_enter_run ##0 (clock_fail_monitor_enable && !clk_ok && !any_src)
         |=> current_osc_select == `RSC_OSC_FRC && clk_ok;
   endproperty
   a_clock_fail_monitor: assert property (p_clock_fail_monitor) else $error("no switch to fast rc");
endmodule

//--- test/rsc_osc_model.sv
// oscillator model: one tick every second clock cycle
`timescale 1ns/1ps
module rsc_osc_model (
   input wire logic aclk,
   input wire logic aresetn,
   output logic osc_tick
);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         osc_tick <= 1'h0;
      else
         osc_tick <= !osc_tick;
   end
endmodule

//--- test/tb_rsc_top.sv
// bench for the reset source controller
`timescale 1ns/1ps
module tb_rsc_top;
   localparam int POR = 10;
   localparam int SU = 12;
   localparam int RST = 8;
   localparam int MON = 20;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, ta, tw, b;
   logic [1:0] bresp, rresp, r;
   logic por_event = 1'h0, brownout_reset = 1'h0, external_pin_reset = 1'h0;
   logic reset_instr = 1'h0, watchdog_timeout = 1'h0, trap_conflict = 1'h0;
   logic illegal_operation = 1'h0, sleep_entry = 1'h0, idle_entry = 1'h0;
   logic wake_request = 1'h0, regulator_enable = 1'h1, fuse_watchdog_enable = 1'h0;
   logic clock_switch_enable = 1'h1, clock_fail_monitor_enable = 1'h0;
   logic [2:0] config_osc_select = 3'h0, current_osc_select;
   logic osc_tick, master_reset_out, clock_released, code_run_enable, monitor_active;
   logic watchdog_enabled, regulator_sleep_active;
   int failures = 0, n_compared = 0, cyc = 0, n;
   rsc_top #(.POR_CYC(POR), .SU_REG_CYC(SU), .SU_NOREG_CYC(50), .RST_CYC(RST),
      .LOCK_CYC(6), .MON_CYC(MON)) dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .por_event, .brownout_reset, .external_pin_reset, .reset_instr,
      .watchdog_timeout, .trap_conflict, .illegal_operation, .sleep_entry, .idle_entry,
      .wake_request, .regulator_enable, .fuse_watchdog_enable, .clock_switch_enable,
      .clock_fail_monitor_enable, .config_osc_select, .osc_tick, .master_reset_out,
      .clock_released, .code_run_enable, .monitor_active, .current_osc_select,
      .watchdog_enabled, .regulator_sleep_active);
   rsc_osc_model osc (.aclk, .aresetn, .osc_tick);
   // ==========================================
   // bus and compare tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end while (!b);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(negedge aclk);
         ta = arvalid && arready;
         b = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
      end while (!b);
      rready <= 1'h0;
   endtask
   // counts cycles until master reset is released
   task automatic wrel();
      n = 0;
      @(negedge aclk);
      while (master_reset_out === 1'h1)
      begin
         n++;
         @(negedge aclk);
      end
   endtask
   task automatic pin();
      @(posedge aclk);
      external_pin_reset <= 1'h1;
      @(negedge aclk);
      chk(master_reset_out, 32'h1);
      @(posedge aclk);
      external_pin_reset <= 1'h0;
      wrel();
   endtask
   task automatic por();
      @(posedge aclk);
      por_event <= 1'h1;
      @(posedge aclk);
      por_event <= 1'h0;
      wrel();
   endtask
   task automatic report_and_stop();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_power();
      wrel();
      chk(n >= POR + SU + RST - 2 && n <= POR + SU + RST + 2, 32'h1);
      rd(8'h00);
      chk(d, 32'h0003);
      $display("end of test power");
   endtask
   task automatic t_pin();
      pin();
      chk(n >= RST - 1 && n <= RST + 1, 32'h1);
      rd(8'h00);
      chk(d, 32'h0083);
      $display("end of test pin");
   endtask
   task automatic t_soft();
      wr(8'h00, 32'hFFFF);
      chk(r, 32'h0);
      chk(master_reset_out, 32'h0);
      rd(8'h00);
      chk(d, 32'hC1FF);
      chk(regulator_sleep_active, 32'h1);
      wr(8'h08, 32'h1);
      chk(r, 32'h3);
      rd(8'h0C);
      chk({d[29:0], r}, 32'h3);
      watchdog_timeout <= 1'h1;
      wr(8'h00, 32'h0003);
      watchdog_timeout <= 1'h0;
      wrel();
      rd(8'h00);
      chk(d, 32'h0013);
      $display("end of test soft");
   endtask
   task automatic t_flags();
      @(posedge aclk);
      trap_conflict <= 1'h1;
      illegal_operation <= 1'h1;
      reset_instr <= 1'h1;
      watchdog_timeout <= 1'h1;
      @(posedge aclk);
      trap_conflict <= 1'h0;
      illegal_operation <= 1'h0;
      reset_instr <= 1'h0;
      watchdog_timeout <= 1'h0;
      wrel();
      rd(8'h00);
      chk(d, 32'hC053);
      @(posedge aclk);
      sleep_entry <= 1'h1;
      @(posedge aclk);
      sleep_entry <= 1'h0;
      idle_entry <= 1'h1;
      @(posedge aclk);
      idle_entry <= 1'h0;
      rd(8'h00);
      chk(d, 32'hC04F);
      pin();
      @(posedge aclk);
      brownout_reset <= 1'h1;
      @(posedge aclk);
      brownout_reset <= 1'h0;
      wrel();
      rd(8'h00);
      chk(d, 32'h0083);
      $display("end of test flags");
   endtask
   task automatic t_wdog();
      wr(8'h00, 32'h0003);
      chk(watchdog_enabled, 32'h0);
      wr(8'h00, 32'h0023);
      chk(watchdog_enabled, 32'h1);
      wr(8'h00, 32'h0003);
      fuse_watchdog_enable <= 1'h1;
      @(negedge aclk);
      chk(watchdog_enabled, 32'h1);
      $display("end of test watchdog");
   endtask
   task automatic t_osc();
      config_osc_select <= 3'h4;
      pin();
      chk(current_osc_select, 32'h0);
      clock_switch_enable <= 1'h0;
      pin();
      chk(current_osc_select, 32'h4);
      @(posedge aclk);
      clock_switch_enable <= 1'h1;
      config_osc_select <= 3'h2;
      por_event <= 1'h1;
      @(posedge aclk);
      por_event <= 1'h0;
      wrel();
      chk(current_osc_select, 32'h2);
      chk({clock_released, code_run_enable}, 32'h0);
      rd(8'h00);
      chk(d, 32'h0003);
      while (clock_released !== 1'h1)
      begin
         n++;
         @(negedge aclk);
      end
      chk(n >= 1980 && n <= 2060, 32'h1);
      chk(code_run_enable, 32'h1);
      $display("end of test oscillator");
   endtask
   task automatic t_mon();
      @(posedge aclk);
      wake_request <= 1'h1;
      @(posedge aclk);
      wake_request <= 1'h0;
      @(negedge aclk);
      chk(code_run_enable, 32'h0);
      repeat (SU - 1) @(negedge aclk);
      chk(code_run_enable, 32'h0);
      @(negedge aclk);
      chk(code_run_enable, 32'h1);
      clock_fail_monitor_enable <= 1'h1;
      config_osc_select <= 3'h1;
      por();
      chk({clock_released, monitor_active}, 32'h2);
      repeat (MON) @(negedge aclk);
      chk(monitor_active, 32'h0);
      @(negedge aclk);
      chk(monitor_active, 32'h1);
      config_osc_select <= 3'h2;
      por();
      @(negedge aclk);
      chk({current_osc_select, clock_released, monitor_active}, 32'h3);
      $display("end of test monitor");
   endtask
   initial forever #4 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         failures++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      t_power();
      t_pin();
      t_soft();
      t_flags();
      t_wdog();
      t_osc();
      t_mon();
      report_and_stop();
   end
endmodule
